// >>> hdl/icm_pkg.sv
// constants for one interval counter channel: control word fields, modes, limits
// assumes the surrounding bus decode delivers control and count byte strobes
package icm_pkg;
	localparam int CNT_W = 16;
	// control word fields
	localparam int CW_BCD_BIT = 0;
	localparam int CW_MODE_LSB = 1;
	localparam int CW_MODE_MSB = 3;
	localparam int CW_ACC_LSB = 4;
	localparam int CW_ACC_MSB = 5;
	// access encodings
	localparam logic [1:0] ACC_LATCH = 2'h0;
	localparam logic [1:0] ACC_LSB = 2'h1;
	localparam logic [1:0] ACC_MSB = 2'h2;
	localparam logic [1:0] ACC_BOTH = 2'h3;
	// wrap limits
	localparam logic [15:0] MAX_BIN = 16'hFFFF;
	localparam logic [15:0] MAX_BCD = 16'h9999;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_TWO = 16'h0002;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// counting modes after decode
	typedef enum logic [2:0] {
		ICM_M0 = 3'h0,
		ICM_M1 = 3'h1,
		ICM_M2 = 3'h2,
		ICM_M3 = 3'h3,
		ICM_M4 = 3'h4,
		ICM_M5 = 3'h5
	} icm_mode_e;
	// channel sequencing, gray coded along idle -> wait load -> run
	typedef enum logic [1:0] {
		ICM_IDLE = 2'h0,
		ICM_LOAD = 2'h1,
		ICM_RUN = 2'h3
	} icm_state_e;
endpackage

// >>> hdl/icm_counter.sv
// one down-counter channel with all six counting modes and gate trigger capture
// assumes cw/count strobes are one clk_in pulses and cnt_clk/gate are synchronous levels
`timescale 1ns/1ps
// Functional notes
// - mode 0 out low until terminal count
// - gate level enables counting in 0,2,3,4
// - mode 0 load pulse does not decrement
// - mode 0 first byte halts, drives low
// - mode 0 count loads even with gate low
// - mode 1 out low after trigger until zero
// - mode 1 trigger reloads, gate not on out
// - mode 2 one low pulse at count one
// - modes 2,3 gate low forces out high
// - modes 2,3 trigger reloads next pulse
// - mode 2 new count waits for period end
// - mode 3 square wave, even counts half high half low
// - mode 3 new count waits half-cycle end
// - mode 3 even count subtracts two
// - mode 3 odd count loads count minus one
// - mode 4 write triggers, one low pulse
// - mode 4 new count reloads next pulse
// - mode 5 gate edge triggers strobe
// - mode 5 new count waits for trigger
// - gate rising edge captured until sampled
// - modes 0,1,4,5 wrap to maximum
// - control word resets logic and out
// - format bit selects binary or decimal
module icm_counter (
	input wire logic clk_in, // system clock, 25 MHz
	input wire logic rst_n_in, // async reset, active low
	input wire logic cw_wr_in, // control word write strobe
	input wire logic [7:0] cw_data_in, // control word value
	input wire logic cnt_wr_in, // count byte write strobe
	input wire logic [7:0] cnt_data_in, // count byte value
	input wire logic cnt_clk_in, // counter clock level
	input wire logic gate_in, // gate level
	output logic out_out, // counter output pin
	output logic [15:0] count_out, // counting element value
	output logic null_count_out // written count not yet loaded
);
	// registered state
	icm_pkg::icm_mode_e mode, next_mode;
	icm_pkg::icm_state_e state, next_state;
	logic bcd, next_bcd;
	logic [1:0] acc, next_acc;
	logic msb_pending, next_msb_pending;
	logic [7:0] lsb_hold, next_lsb_hold;
	logic [15:0] init_cnt, next_init_cnt;
	logic [15:0] cnt, next_cnt;
	logic new_cnt, next_new_cnt;
	logic out_q, next_out_q;
	logic trig, next_trig;
	logic gate_q, next_gate_q;
	logic clk_q, next_clk_q;
	logic low_wait, next_low_wait;
	// helpers
	logic clk_rise;
	logic count_en;
	logic cnt_done;
	logic [15:0] wr_val;
	logic [15:0] dec1;
	logic [15:0] dec2;
	logic [15:0] init_even;

	// decimal-or-binary subtract of a small step, wrapping to the format maximum
	function automatic logic [15:0] sub_step(input logic [15:0] v, input logic [15:0] s,
		input logic is_bcd);
		logic [15:0] r;
		logic [4:0] d;
		logic borrow;
		r = 16'h0000;
		borrow = 1'b0;
		if (!is_bcd) begin
			r = v - s;
		end else begin
			for (int i = 0; i < 4; i++) begin
				d = {1'b0, v[i*4 +: 4]} - {1'b0, s[i*4 +: 4]} - {4'h0, borrow};
				borrow = d[4];
				if (borrow) begin
					d = d + 5'h0A;
				end
				r[i*4 +: 4] = d[3:0];
			end
		end
		return r;
	endfunction

	assign clk_rise = cnt_clk_in && !clk_q;
	assign dec1 = sub_step(cnt, icm_pkg::CNT_ONE, bcd);
	assign dec2 = sub_step(cnt, icm_pkg::CNT_TWO, bcd);
	// odd counts run from count minus one; zero stands for the full range
	assign init_even = {init_cnt[15:1], 1'b0};
	assign cnt_done = (cnt == icm_pkg::CNT_ZERO);
	// gate level only counts in the level-sensitive modes
	always_comb begin
		case (mode)
			icm_pkg::ICM_M1, icm_pkg::ICM_M5: count_en = 1'b1;
			default: count_en = gate_in;
		endcase
	end

	// assemble the written count value per access format
	always_comb begin
		case (acc)
			icm_pkg::ACC_MSB: wr_val = {cnt_data_in, icm_pkg::BYTE_ZERO};
			icm_pkg::ACC_BOTH: wr_val = {cnt_data_in, lsb_hold};
			default: wr_val = {icm_pkg::BYTE_ZERO, cnt_data_in};
		endcase
	end

	// next-state logic for the whole channel
	always_comb begin
		next_mode = mode;
		next_state = state;
		next_bcd = bcd;
		next_acc = acc;
		next_msb_pending = msb_pending;
		next_lsb_hold = lsb_hold;
		next_init_cnt = init_cnt;
		next_cnt = cnt;
		next_new_cnt = new_cnt;
		next_out_q = out_q;
		next_trig = trig;
		next_gate_q = gate_in;
		next_clk_q = cnt_clk_in;
		next_low_wait = low_wait;
		// gate edge capture, held until a counter clock edge samples it
		if (gate_in && !gate_q) begin
			next_trig = 1'b1;
		end else if (clk_rise) begin
			next_trig = 1'b0;
		end
		// gate low while output low ends the pulse at once
		if ((mode == icm_pkg::ICM_M2 || mode == icm_pkg::ICM_M3) && !gate_in) begin
			next_out_q = 1'b1;
		end
		if (cw_wr_in) begin
			// control word: reset control logic, clear holding bytes
			if (cw_data_in[icm_pkg::CW_ACC_MSB:icm_pkg::CW_ACC_LSB] != icm_pkg::ACC_LATCH) begin
				next_acc = cw_data_in[icm_pkg::CW_ACC_MSB:icm_pkg::CW_ACC_LSB];
				next_bcd = cw_data_in[icm_pkg::CW_BCD_BIT];
				case (cw_data_in[icm_pkg::CW_MODE_MSB:icm_pkg::CW_MODE_LSB])
					3'h0: next_mode = icm_pkg::ICM_M0;
					3'h1: next_mode = icm_pkg::ICM_M1;
					3'h2, 3'h6: next_mode = icm_pkg::ICM_M2;
					3'h3, 3'h7: next_mode = icm_pkg::ICM_M3;
					3'h4: next_mode = icm_pkg::ICM_M4;
					default: next_mode = icm_pkg::ICM_M5;
				endcase
				// mode 0 starts low, every other mode starts high
				next_out_q = (cw_data_in[icm_pkg::CW_MODE_MSB:icm_pkg::CW_MODE_LSB] != 3'h0);
				next_state = icm_pkg::ICM_IDLE;
				next_msb_pending = 1'b0;
				next_lsb_hold = icm_pkg::BYTE_ZERO;
				next_init_cnt = icm_pkg::CNT_ZERO;
				next_new_cnt = 1'b0;
				next_trig = 1'b0;
				next_low_wait = 1'b0;
			end
		end else if (cnt_wr_in && acc == icm_pkg::ACC_BOTH && !msb_pending) begin
			// first of two bytes: only mode 0 reacts to it
			next_lsb_hold = cnt_data_in;
			next_msb_pending = 1'b1;
			if (mode == icm_pkg::ICM_M0) begin
				next_out_q = 1'b0;
				next_state = icm_pkg::ICM_IDLE;
			end
		end else if (cnt_wr_in) begin
			next_msb_pending = 1'b0;
			next_init_cnt = wr_val;
			next_new_cnt = 1'b1;
			case (mode)
				icm_pkg::ICM_M0: begin
					next_out_q = 1'b0;
					next_state = icm_pkg::ICM_LOAD;
				end
				icm_pkg::ICM_M4: begin
					next_state = icm_pkg::ICM_LOAD;
				end
				icm_pkg::ICM_M2, icm_pkg::ICM_M3: begin
					// first count starts the channel; later counts wait for mode 2 period end or mode 3 half-cycle end
					if (state == icm_pkg::ICM_IDLE) begin
						next_state = icm_pkg::ICM_LOAD;
					end
				end
				default: begin
					// one-shot modes stay armed until a gate trigger
				end
			endcase
		end else if (clk_rise) begin
			// trigger in edge modes forces a reload on this pulse
			if (trig && mode != icm_pkg::ICM_M0 && mode != icm_pkg::ICM_M4 &&
				init_cnt != icm_pkg::CNT_ZERO || trig && new_cnt &&
				(mode == icm_pkg::ICM_M1 || mode == icm_pkg::ICM_M5)) begin
				next_cnt = (mode == icm_pkg::ICM_M3) ? init_even : init_cnt;
				next_new_cnt = 1'b0;
				next_state = icm_pkg::ICM_RUN;
				next_low_wait = 1'b0;
				if (mode == icm_pkg::ICM_M1) begin
					next_out_q = 1'b0;
				end else begin
					next_out_q = 1'b1;
				end
			end else begin
				case (state)
					icm_pkg::ICM_LOAD: begin
						// load pulse never decrements
						next_cnt = (mode == icm_pkg::ICM_M3) ? init_even : init_cnt;
						next_new_cnt = 1'b0;
						next_state = icm_pkg::ICM_RUN;
					end
					icm_pkg::ICM_RUN: begin
						if (count_en) begin
							case (mode)
								icm_pkg::ICM_M0, icm_pkg::ICM_M1: begin
									// wrap and keep counting after zero
									next_cnt = dec1;
									if (dec1 == icm_pkg::CNT_ZERO) begin
										next_out_q = 1'b1;
									end
								end
								icm_pkg::ICM_M4, icm_pkg::ICM_M5: begin
									next_cnt = dec1;
									// strobe low for exactly one pulse at expiry
									next_out_q = !(dec1 == icm_pkg::CNT_ZERO &&
										!(out_q == 1'b0));
								end
								icm_pkg::ICM_M2: begin
									if (cnt == icm_pkg::CNT_TWO) begin
										next_cnt = dec1;
										next_out_q = 1'b0;
									end else if (cnt == icm_pkg::CNT_ONE) begin
										// reload picks up any count written meanwhile
										next_cnt = init_cnt;
										next_new_cnt = 1'b0;
										next_out_q = 1'b1;
									end else begin
										next_cnt = dec1;
									end
								end
								default: begin
									// mode 3: odd counts hold high one extra pulse
									if (low_wait) begin
										next_low_wait = 1'b0;
										next_cnt = init_even;
										next_new_cnt = 1'b0;
										next_out_q = 1'b0;
									end else if (cnt == icm_pkg::CNT_TWO) begin
										// half-cycle end: reload, possibly new count
										next_cnt = init_even;
										next_new_cnt = 1'b0;
										if (out_q && init_cnt[0]) begin
											next_low_wait = 1'b1;
											next_cnt = cnt;
										end else begin
											next_out_q = !out_q;
										end
									end else begin
										next_cnt = dec2;
									end
								end
							endcase
						end
					end
					default: begin
						// idle: waiting for a count or a trigger
					end
				endcase
			end
		end
	end

	// register stage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode <= icm_pkg::ICM_M0;
			state <= icm_pkg::ICM_IDLE;
			bcd <= 1'b0;
			acc <= icm_pkg::ACC_LSB;
			msb_pending <= 1'b0;
			lsb_hold <= 8'h00;
			init_cnt <= 16'h0000;
			cnt <= 16'h0000;
			new_cnt <= 1'b0;
			out_q <= 1'b1;
			trig <= 1'b0;
			gate_q <= 1'b0;
			clk_q <= 1'b0;
			low_wait <= 1'b0;
		end else begin
			mode <= next_mode;
			state <= next_state;
			bcd <= next_bcd;
			acc <= next_acc;
			msb_pending <= next_msb_pending;
			lsb_hold <= next_lsb_hold;
			init_cnt <= next_init_cnt;
			cnt <= next_cnt;
			new_cnt <= next_new_cnt;
			out_q <= next_out_q;
			trig <= next_trig;
			gate_q <= next_gate_q;
			clk_q <= next_clk_q;
			low_wait <= next_low_wait;
		end
	end

	assign out_out = out_q;
	assign count_out = cnt;
	assign null_count_out = new_cnt;
endmodule

// >>> tb/icm_counter_monitor.sv
// checker for one counter channel, watching only the channel's ports
// assumes one-clock write strobes and a sampled counter clock level
`timescale 1ns/1ps
module icm_counter_monitor (
	input wire logic clk_in, // system clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic cw_wr_in, // control word strobe
	input wire logic [7:0] cw_data_in, // control word
	input wire logic cnt_wr_in, // count byte strobe
	input wire logic [7:0] cnt_data_in, // count byte
	input wire logic cnt_clk_in, // counter clock level
	input wire logic gate_in, // gate level
	input wire logic out_out, // output pin
	input wire logic [15:0] count_out, // counting element
	input wire logic null_count_out // count pending
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic [2:0] mode;
	logic bcd, clk_q, gate_q, pulse, run, cwv;
	// mirror of the mode; 6 and 7 fold onto 2 and 3, latch commands ignored
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode <= 3'h0;
			bcd <= 1'b0;
			clk_q <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			clk_q <= cnt_clk_in;
			gate_q <= gate_in;
			if (cwv) begin
				mode <= cw_data_in[2] ? {1'b0, cw_data_in[2:1]} : cw_data_in[3:1];
				bcd <= cw_data_in[0];
			end
		end
	end
	// a clean tick: gate steady high, nothing pending, no write in flight
	assign cwv = cw_wr_in && cw_data_in[5:4] != 2'h0;
	assign pulse = cnt_clk_in && !clk_q;
	assign run = pulse && gate_in && gate_q && !null_count_out && !cw_wr_in && !cnt_wr_in;
	sequence s_tick(m);
		run && mode == m;
	endsequence
	a_m0_cw_low: assert property (cwv && cw_data_in[3:1] == 3'h0 |-> ##2 !out_out)
		else $error("out not low after mode 0 control word");
	a_cw_out_high: assert property (cwv && cw_data_in[3:1] != 3'h0 |-> ##2 out_out)
		else $error("out not high after control word");
	a_load_nulls: assert property (pulse && null_count_out && mode == 3'h0 && !cw_wr_in
		&& !cnt_wr_in |=> !null_count_out)
		else $error("mode 0 count not loaded on pulse");
	a_m0_term: assert property (s_tick(3'h0) ##0 count_out == 16'h0001
		|=> out_out && count_out == 16'h0000)
		else $error("mode 0 terminal count wrong");
	a_wrap_max: assert property (run && (mode == 3'h0 || mode == 3'h4) && count_out == 16'h0000
		|=> count_out == (bcd ? 16'h9999 : 16'hFFFF))
		else $error("count did not wrap to maximum");
	a_gate_hold: assert property (pulse && !gate_in && !gate_q && mode == 3'h0
		&& !null_count_out && !cw_wr_in && !cnt_wr_in |=> $stable(count_out))
		else $error("count moved with gate low");
	a_gate_force: assert property ((mode == 3'h2 || mode == 3'h3) && $fell(gate_in)
		&& !cw_wr_in |-> ##[1:2] out_out)
		else $error("gate low did not force out high");
	a_m2_one: assert property (s_tick(3'h2) ##0 count_out == 16'h0002
		|=> !out_out && count_out == 16'h0001)
		else $error("rate pulse missing at count one");
	a_m2_back: assert property (mode == 3'h2 && pulse && !out_out && !cw_wr_in
		&& !cnt_wr_in |=> out_out)
		else $error("rate pulse longer than one tick");
	a_m3_two: assert property (s_tick(3'h3) ##0 count_out > 16'h0002
		|=> count_out == $past(count_out) - 16'h0002)
		else $error("square wave step not two");
endmodule
bind icm_counter icm_counter_monitor mon_u (.clk_in, .rst_n_in, .cw_wr_in, .cw_data_in,
	.cnt_wr_in, .cnt_data_in, .cnt_clk_in, .gate_in, .out_out, .count_out, .null_count_out);

// >>> tb/icm_cpu_model.sv
// processor side: writes control words and count bytes over the port
// assumes the bench calls its tasks; each strobe lasts one clock
`timescale 1ns/1ps
module icm_cpu_model (
	input wire logic clk_in, // system clock
	output logic cw_wr_out, // control word strobe
	output logic [7:0] cw_data_out, // control word
	output logic cnt_wr_out, // count byte strobe
	output logic [7:0] cnt_data_out // count byte
);
	logic rate_mode = 1'b0;
	// idle values so nothing reads as a write before the first call
	initial begin
		cw_wr_out = 1'b0;
		cw_data_out = 8'h00;
		cnt_wr_out = 1'b0;
		cnt_data_out = 8'h00;
	end
	// data is inverted once released, so a stale byte never looks valid
	task automatic wr_cw(input logic [7:0] d);
		@(posedge clk_in);
		cw_wr_out <= 1'b1;
		cw_data_out <= d;
		rate_mode = (d[2:1] == 2'h2);
		@(posedge clk_in);
		cw_wr_out <= 1'b0;
		cw_data_out <= ~d;
	endtask
	task automatic wr_cnt(input logic [7:0] d);
		logic [7:0] v;
		v = (rate_mode && d == 8'h01) ? 8'h02 : d; // never a count of one in mode 2
		@(posedge clk_in);
		cnt_wr_out <= 1'b1;
		cnt_data_out <= v;
		@(posedge clk_in);
		cnt_wr_out <= 1'b0;
		cnt_data_out <= ~v;
	endtask
endmodule

// >>> tb/icm_counter_tb_top.sv
// bench for the counter channel: table of mode cases, then edge cases
// assumes the channel, the processor model and the checker bind
`timescale 1ns/1ps
module icm_counter_tb_top;
	typedef struct packed {
		logic [7:0] cw;
		logic [7:0] cnt;
		logic [3:0] n;
		logic [15:0] cnt_exp;
		logic out_exp;
	} icm_row_s;
	logic clk_in;
	logic rst_n_in;
	logic cnt_clk_in;
	logic gate_in;
	logic cw_wr_in, cnt_wr_in, out_out, null_count_out;
	logic [7:0] cw_data_in, cnt_data_in;
	logic [15:0] count_out;
	int err_count = 0;
	int check_count = 0;
	// control word, count, pulses, expected count and out
	icm_row_s rows [11] = '{
		'{8'h10, 8'h03, 4'h1, 16'h0003, 1'h0}, '{8'h10, 8'h03, 4'h4, 16'h0000, 1'h1},
		'{8'h10, 8'h03, 4'h5, 16'hFFFF, 1'h1}, '{8'h11, 8'h01, 4'h3, 16'h9999, 1'h1},
		'{8'h14, 8'h03, 4'h3, 16'h0001, 1'h0}, '{8'h14, 8'h03, 4'h4, 16'h0003, 1'h1},
		'{8'h16, 8'h04, 4'h2, 16'h0002, 1'h1}, '{8'h16, 8'h04, 4'h3, 16'h0004, 1'h0},
		'{8'h16, 8'h05, 4'h1, 16'h0004, 1'h1}, '{8'h18, 8'h02, 4'h3, 16'h0000, 1'h0},
		'{8'h18, 8'h02, 4'h4, 16'hFFFF, 1'h1}};
	icm_counter dut_u (.clk_in, .rst_n_in, .cw_wr_in, .cw_data_in, .cnt_wr_in, .cnt_data_in,
		.cnt_clk_in, .gate_in, .out_out, .count_out, .null_count_out);
	icm_cpu_model cpu_u (.clk_in, .cw_wr_out(cw_wr_in), .cw_data_out(cw_data_in),
		.cnt_wr_out(cnt_wr_in), .cnt_data_out(cnt_data_in));
	// start values of the bench-driven pins; scenarios move them later
	initial begin
		clk_in = 1'b0;
		rst_n_in = 1'b0;
		cnt_clk_in = 1'b0;
		gate_in = 1'b1;
		forever #20 clk_in = ~clk_in;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one counter clock pulse spans four system clocks, never beside a write
	task automatic pulse(input logic [3:0] n);
		repeat (n) begin
			@(posedge clk_in);
			cnt_clk_in <= 1'b1;
			repeat (2) @(posedge clk_in);
			cnt_clk_in <= 1'b0;
			@(posedge clk_in);
		end
		#1;
	endtask
	task automatic set_gate(input logic v);
		@(posedge clk_in);
		gate_in <= v;
	endtask
	task automatic trig;
		set_gate(1'b1);
		set_gate(1'b0);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		chk({out_out, null_count_out, count_out[13:0]}, 16'h8000);
		rst_n_in <= 1'b1;
		foreach (rows[i]) begin
			cpu_u.wr_cw(rows[i].cw);
			cpu_u.wr_cnt(rows[i].cnt);
			pulse(rows[i].n);
			chk(count_out, rows[i].cnt_exp);
			chk(16'(out_out), 16'(rows[i].out_exp));
		end
		// count loads with the gate low, then gate low holds it
		set_gate(1'b0);
		cpu_u.wr_cw(8'h10);
		cpu_u.wr_cnt(8'h02);
		pulse(1);
		chk(count_out, 16'h0002);
		pulse(2);
		chk(count_out, 16'h0002);
		set_gate(1'b1);
		pulse(1);
		chk(count_out, 16'h0001);
		// two-byte count: first byte halts, second reloads
		cpu_u.wr_cw(8'h30);
		cpu_u.wr_cnt(8'h05);
		cpu_u.wr_cnt(8'h00);
		pulse(2);
		cpu_u.wr_cnt(8'h09);
		pulse(1);
		chk(count_out, 16'h0004);
		chk(16'(out_out), 16'h0000);
		cpu_u.wr_cnt(8'h00);
		#1;
		chk(16'(null_count_out), 16'h0001);
		pulse(1);
		chk(count_out, 16'h0009);
		// rate mode: mid-period trigger reloads, gate fall lifts the low pulse
		cpu_u.wr_cw(8'h14);
		cpu_u.wr_cnt(8'h03);
		pulse(2);
		set_gate(1'b0);
		set_gate(1'b1);
		pulse(1);
		chk(count_out, 16'h0003);
		pulse(2);
		chk(16'(out_out), 16'h0000);
		set_gate(1'b0);
		repeat (2) @(posedge clk_in);
		#1;
		chk(16'(out_out), 16'h0001);
		// mode 4 count rewritten while running
		cpu_u.wr_cw(8'h18);
		cpu_u.wr_cnt(8'h05);
		pulse(2);
		cpu_u.wr_cnt(8'h02);
		pulse(1);
		chk(count_out, 16'h0002);
		// one-shot with a retrigger part way
		cpu_u.wr_cw(8'h12);
		cpu_u.wr_cnt(8'h04);
		trig();
		pulse(1);
		chk({out_out, count_out[14:0]}, 16'h0004);
		pulse(1);
		trig();
		pulse(1);
		chk(count_out, 16'h0004);
		pulse(4);
		chk(16'(out_out), 16'h0001);
		// hardware strobe waits for a short gate pulse
		cpu_u.wr_cw(8'h1A);
		cpu_u.wr_cnt(8'h03);
		pulse(1);
		chk(16'(null_count_out), 16'h0001);
		trig();
		pulse(1);
		chk(count_out, 16'h0003);
		pulse(3);
		chk(16'(out_out), 16'h0000);
		pulse(1);
		chk(16'(out_out), 16'h0001);
		wrap_up();
	end
	// about 350 clocks are needed; this margin only catches a hang
	initial begin
		repeat (4000) @(posedge clk_in);
		$display("[ERR] %0t watchdog expired", $time);
		err_count++;
		wrap_up();
	end
endmodule
